// ---- pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_i,   // system clock
  input  wire logic         rst_n_i, // synchronous reset, active low
  input  wire logic [W-1:0] pin_i,   // asynchronous pin levels
  output logic      [W-1:0] level_o  // filtered level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] level;
  logic [W-1:0] next_level;

  // a bit moves only when the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_level[i] = (s2[i] == s3[i]) ? s3[i] : level[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1    <= INIT;
      s2    <= INIT;
      s3    <= INIT;
      level <= INIT;
    end else begin
      s1    <= pin_i;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

  assign level_o = level;

endmodule : pin_sync

// ---- stepper_cfg.svh ----
// constants of the stepping motor phase gate and fault latch
// What the document requires
// R1: active-low phase inputs drive own winding; paired phases never on together
// R2: holding the system reset input low keeps internal logic in reset
// R3: enable low forces all four winding outputs off; high runs normally
// R4: fault output goes low whenever overcurrent or overheat detection triggered
// R5: any detection latches all winding outputs off after the cause disappears
// R6: outputs resume only after power-on reset or a high-low-high reset pulse
// R7: power-on reset near 4 V logic supply initialises all internal logic
// R8: overcurrent and set-current sensing are masked 5.5 us after PWM turn-on
// R9: overcurrent detector trips near 3.5 A winding current
// R10: overheat detector trips near 144 C substrate temperature
// R11: controller keeps enable low while logic supply is under 4.75 V
// R12: controller stops the motor by gradually lengthening the phase period
`ifndef STEPPER_CFG_SVH
`define STEPPER_CFG_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_HZ      10000000
`define CLK_NS      100
`define BLANK_NS    5500
// least time: round up to whole cycles
`define BLANK_CYC   ((`BLANK_NS + `CLK_NS - 1) / `CLK_NS)
`define PWM_HZ      45000
`define PWM_CYC     (`CLK_HZ / `PWM_HZ)
`define CNT_W       8

// ****************************************************************
// reset values of synchronised pins
// ****************************************************************
`define PHASE_IDLE  4'hf
`define CTRL_IDLE   2'h0
`define DET_IDLE    3'h0

// ****************************************************************
// phase vector bit positions
// ****************************************************************
`define PH_A        0
`define PH_A_BAR    1
`define PH_B        2
`define PH_B_BAR    3

`endif

// ---- stepper_ctrl_model.sv ----
// behavioural model of the controller that sequences the phase pins
`timescale 1ns/1ps
module stepper_ctrl_model (
  input  wire logic       clk_i,       // system clock
  input  wire logic       supply_ok_i, // logic supply above 4.75 V
  input  wire logic       go_i,        // keep rotating
  input  wire logic       clash_i,     // request both phases of each pair
  output logic      [3:0] phase_n_o,   // {b_bar,b,a_bar,a}, active low
  output logic            enable_o     // output enable pin
);
  // ********
  // two-phase excitation sequencer
  // ********
  logic [3:0] tbl [4] = '{4'h5, 4'h6, 4'ha, 4'h9};
  int         per     = 400;
  int         cnt     = 0;
  logic [1:0] step    = 2'h0;

  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt >= per) begin
      cnt <= 0;
      // slowing down rather than halting avoids overshoot
      if (go_i || per < 800) step <= step + 2'h1;
      per <= go_i ? 400 : per + 100;
    end
  end
  assign phase_n_o = clash_i ? 4'h0 : ~tbl[step];
  assign enable_o  = supply_ok_i;
endmodule : stepper_ctrl_model

// ---- stepper_phase_gate_fault_latch.sv ----
// phase gating, pwm chopping and fault latch of a two-phase stepper driver
`timescale 1ns/1ps
`include "stepper_cfg.svh"
module stepper_phase_gate_fault_latch (
  input  wire logic clk_i,            // 10 MHz internal oscillator
  input  wire logic rst_n_i,          // power-on reset, active low
  input  wire logic phase_a_n_i,      // phase a request, active low
  input  wire logic phase_a_bar_n_i,  // phase a-bar request, active low
  input  wire logic phase_b_n_i,      // phase b request, active low
  input  wire logic phase_b_bar_n_i,  // phase b-bar request, active low
  input  wire logic system_reset_n_i, // system reset pin, active low
  input  wire logic enable_i,         // output enable, low cuts outputs
  input  wire logic over_set_i,       // current above set value
  input  wire logic overcurrent_i,    // overcurrent comparator trip
  input  wire logic overheat_i,       // substrate overheat trip
  output logic      winding_a_o,      // phase a winding on
  output logic      winding_a_bar_o,  // phase a-bar winding on
  output logic      winding_b_o,      // phase b winding on
  output logic      winding_b_bar_o,  // phase b-bar winding on
  output logic      fault_n_o         // fault flag, active low
);

  localparam logic [`CNT_W-1:0] PWM_LAST   = `CNT_W'(`PWM_CYC - 1);
  localparam logic [`CNT_W-1:0] BLANK_DONE = `CNT_W'(`BLANK_CYC);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] phase_n;
  logic [1:0] ctrl;
  logic [2:0] det;

  pin_sync #(.W(4), .INIT(`PHASE_IDLE)) u_sync_phase (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({phase_b_bar_n_i, phase_b_n_i, phase_a_bar_n_i, phase_a_n_i}),
    .level_o (phase_n)
  );

  // reset pin idles low so no output moves before it is seen high
  pin_sync #(.W(2), .INIT(`CTRL_IDLE)) u_sync_ctrl (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({enable_i, system_reset_n_i}),
    .level_o (ctrl)
  );

  pin_sync #(.W(3), .INIT(`DET_IDLE)) u_sync_det (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({overheat_i, overcurrent_i, over_set_i}),
    .level_o (det)
  );

  logic sys_reset_n;
  logic enable;
  logic over_set;
  logic overcurrent;
  logic overheat;

  assign sys_reset_n = ctrl[0];
  assign enable      = ctrl[1];
  assign over_set    = det[0];
  assign overcurrent = det[1];
  assign overheat    = det[2];

  // ****************************************************************
  // fault latch state
  // ****************************************************************
  stepper_pkg::drive_state_t state;
  stepper_pkg::drive_state_t next_state;
  logic                      blank_done;
  logic                      trip;

  // overheat is a slow thermal level, so it is never blanked
  assign trip = (blank_done && overcurrent) || overheat; // see R9 see R10

  always_comb begin
    next_state = state;
    case (state)
      stepper_pkg::ST_RESET: begin
        // held here while the reset pin is low
        if (sys_reset_n) begin // see R2
          next_state = stepper_pkg::ST_RUN;
        end
      end
      stepper_pkg::ST_RUN: begin
        if (!sys_reset_n) begin
          next_state = stepper_pkg::ST_RESET;
        end else if (trip) begin
          next_state = stepper_pkg::ST_FAULT; // see R5
        end
      end
      stepper_pkg::ST_FAULT: begin
        // only a low phase of the reset pin, or power-on reset, releases the latch
        if (!sys_reset_n) begin
          next_state = stepper_pkg::ST_RESET; // see R6
        end
      end
      default: begin
        next_state = stepper_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= stepper_pkg::ST_RESET; // see R7
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // pwm chopping with leading-edge blanking
  // ****************************************************************
  logic [`CNT_W-1:0] pwm_cnt;
  logic [`CNT_W-1:0] next_pwm_cnt;
  logic [`CNT_W-1:0] blank_cnt;
  logic [`CNT_W-1:0] next_blank_cnt;
  logic              chop_on;
  logic              next_chop_on;
  logic              pwm_start;

  assign pwm_start  = (pwm_cnt == PWM_LAST);
  assign blank_done = (blank_cnt == BLANK_DONE);

  always_comb begin
    next_pwm_cnt   = pwm_start ? '0 : pwm_cnt + `CNT_W'(1);
    next_blank_cnt = blank_cnt;
    next_chop_on   = chop_on;
    if (state != stepper_pkg::ST_RUN) begin
      next_pwm_cnt   = '0;
      next_blank_cnt = '0;
      next_chop_on   = 1'b0;
    end else if (pwm_start) begin
      // each period turns on and restarts the mask window
      next_chop_on   = 1'b1;
      next_blank_cnt = '0; // see R8
    end else begin
      if (!blank_done) begin
        next_blank_cnt = blank_cnt + `CNT_W'(1); // see R8
      end
      // ringing right after turn-on must not chop the current
      if (blank_done && over_set) begin
        next_chop_on = 1'b0; // see R8
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pwm_cnt   <= '0;
      blank_cnt <= '0;
      chop_on   <= 1'b0;
    end else begin
      pwm_cnt   <= next_pwm_cnt;
      blank_cnt <= next_blank_cnt;
      chop_on   <= next_chop_on;
    end
  end

  // ****************************************************************
  // winding gate and fault output
  // ****************************************************************
  logic [3:0] req;
  logic [3:0] drive;
  logic [3:0] next_drive;
  logic       fault_n;
  logic       next_fault_n;
  logic       run_ok;

  assign req    = ~phase_n; // see R1
  assign run_ok = (state == stepper_pkg::ST_RUN) && !trip && enable // see R3
                  && chop_on;

  always_comb begin
    next_drive = 4'h0;
    if (run_ok) begin
      // a conflicting pair turns both of its windings off
      if (!(req[`PH_A] && req[`PH_A_BAR])) begin // see R1
        next_drive[`PH_A]     = req[`PH_A];
        next_drive[`PH_A_BAR] = req[`PH_A_BAR];
      end
      if (!(req[`PH_B] && req[`PH_B_BAR])) begin // see R1
        next_drive[`PH_B]     = req[`PH_B];
        next_drive[`PH_B_BAR] = req[`PH_B_BAR];
      end
    end
    next_fault_n = !(next_state == stepper_pkg::ST_FAULT); // see R4
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      drive   <= 4'h0;
      fault_n <= 1'b1;
    end else begin
      drive   <= next_drive;
      fault_n <= next_fault_n;
    end
  end

  assign winding_a_o     = drive[`PH_A];
  assign winding_a_bar_o = drive[`PH_A_BAR];
  assign winding_b_o     = drive[`PH_B];
  assign winding_b_bar_o = drive[`PH_B_BAR];
  assign fault_n_o       = fault_n;

endmodule : stepper_phase_gate_fault_latch

// ---- stepper_phase_gate_fault_latch_sva.sv ----
// port assertions of the stepper phase gate and fault latch
`timescale 1ns/1ps
module stepper_sva (
  input wire logic clk_i,            // clock
  input wire logic rst_n_i,          // reset
  input wire logic phase_a_n_i,      // phase a
  input wire logic phase_a_bar_n_i,  // phase a-bar
  input wire logic phase_b_n_i,      // phase b
  input wire logic phase_b_bar_n_i,  // phase b-bar
  input wire logic system_reset_n_i, // reset pin
  input wire logic enable_i,         // enable
  input wire logic over_set_i,       // over set
  input wire logic overcurrent_i,    // overcurrent
  input wire logic overheat_i,       // overheat
  input wire logic winding_a_o,      // winding a
  input wire logic winding_a_bar_o,  // winding a-bar
  input wire logic winding_b_o,      // winding b
  input wire logic winding_b_bar_o,  // winding b-bar
  input wire logic fault_n_o         // fault
);
  // ********
  // properties
  // ********
  wire any_w = winding_a_o | winding_a_bar_o | winding_b_o | winding_b_bar_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_pair_a; !(winding_a_o && winding_a_bar_o); endproperty
  a_pair_a: assert property (p_pair_a) else $error("pair a on");
  property p_pair_b; !(winding_b_o && winding_b_bar_o); endproperty
  a_pair_b: assert property (p_pair_b) else $error("pair b on");
  property p_por; $rose(rst_n_i) |-> fault_n_o && !any_w; endproperty
  a_por: assert property (p_por) else $error("bad after reset");
  property p_enable; !enable_i [*6] |-> !any_w; endproperty
  a_enable: assert property (p_enable) else $error("on while off");
  property p_sysrst; !system_reset_n_i [*7] |-> !any_w && fault_n_o;
  endproperty
  a_sysrst: assert property (p_sysrst) else $error("reset pin");
  property p_off; !fault_n_o |-> !any_w; endproperty
  a_off: assert property (p_off) else $error("on in fault");
  property p_hold; system_reset_n_i [*6] ##0 !fault_n_o |=> !fault_n_o;
  endproperty
  a_hold: assert property (p_hold) else $error("fault let go");
  property p_trip; (overheat_i && system_reset_n_i) [*8] |-> !fault_n_o;
  endproperty
  a_trip: assert property (p_trip) else $error("no fault");
  c_fault: cover property ($fell(fault_n_o));
  c_run: cover property ($rose(winding_a_o));
  c_clash: cover property (!phase_a_n_i && !phase_a_bar_n_i);
endmodule : stepper_sva

bind stepper_phase_gate_fault_latch stepper_sva u_sva (.*);

// ---- stepper_phase_gate_fault_latch_tb.sv ----
// self-checking bench of the stepper phase gate and fault latch
`timescale 1ns/1ps
module stepper_phase_gate_fault_latch_tb;
  // ********
  // bench signals and instances
  // ********
  logic       clk_i = 1'b0, rst_n_i = 1'b0, sys_n = 1'b0, sup = 1'b0;
  logic       go = 1'b1, clash = 1'b0, ocur = 1'b0, heat = 1'b0, oset = 1'b0;
  logic [3:0] ph_n;
  wire  [3:0] win;
  logic       en, fault_n;
  int         num_errors = 0, total_checks = 0;
  always #50 clk_i = ~clk_i;
  stepper_ctrl_model ctrl (.clk_i(clk_i), .supply_ok_i(sup), .go_i(go),
    .clash_i(clash), .phase_n_o(ph_n), .enable_o(en));
  stepper_phase_gate_fault_latch DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .phase_a_n_i(ph_n[0]), .phase_a_bar_n_i(ph_n[1]),
    .phase_b_n_i(ph_n[2]), .phase_b_bar_n_i(ph_n[3]),
    .system_reset_n_i(sys_n), .enable_i(en), .over_set_i(oset),
    .overcurrent_i(ocur), .overheat_i(heat), .winding_a_o(win[0]),
    .winding_a_bar_o(win[1]), .winding_b_o(win[2]),
    .winding_b_bar_o(win[3]), .fault_n_o(fault_n));
  // ********
  // helpers
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [4:0] exp);
    total_checks++;
    if ({fault_n, win} !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, {fault_n, win}, exp);
    end
  endtask : chk
  task automatic wait_on();
    for (int i = 0; i < 600 && win === 4'h0; i++) tick(1);
  endtask : wait_on
  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // ********
  // scenarios
  // ********
  task automatic t_run();
    logic [3:0] ph;
    wait_on();
    repeat (4) begin
      ph = ph_n;
      tick(10);
      if (ph_n === ph) chk({1'b1, ~ph});
      tick(100);
    end
  endtask : t_run
  task automatic t_chop();
    // oset is first seen just after a fresh mask window opens, so the first look still sees drive
    oset = 1'b1;
    tick(30);
    chk({1'b1, ~ph_n});
    tick(50);
    chk(5'h10);
    oset = 1'b0;
  endtask : t_chop
  task automatic t_gate();
    clash = 1'b1;
    tick(10);
    chk(5'h10);
    clash = 1'b0;
    sup = 1'b0;
    tick(10);
    chk(5'h10);
    sup = 1'b1;
  endtask : t_gate
  task automatic t_trip();
    sys_n = 1'b0;
    tick(10);
    sys_n = 1'b1;
    wait_on();
    // a spike right after turn-on is ringing, not a short
    ocur = 1'b1;
    tick(20);
    ocur = 1'b0;
    tick(10);
    chk({1'b1, ~ph_n});
    ocur = 1'b1;
    tick(80);
    chk(5'h00);
    ocur = 1'b0;
    tick(20);
    chk(5'h00);
    sys_n = 1'b0;
    tick(10);
    chk(5'h10);
    sys_n = 1'b1;
    t_run();
  endtask : t_trip
  task automatic t_heat();
    heat = 1'b1;
    tick(10);
    heat = 1'b0;
    tick(10);
    chk(5'h00);
    rst_n_i = 1'b0;
    tick(3);
    chk(5'h10);
    rst_n_i = 1'b1;
    t_run();
  endtask : t_heat
  // ********
  // main sequence and watchdog
  // ********
  initial begin
    tick(20);
    rst_n_i = 1'b1;
    sys_n = 1'b1;
    sup = 1'b1;
    t_run();
    t_chop();
    t_gate();
    t_trip();
    t_heat();
    finish_test();
  end
  initial begin
    #(50000 * 100);
    num_errors++;
    finish_test();
  end
endmodule : stepper_phase_gate_fault_latch_tb

// ---- stepper_pkg.sv ----
// types of the stepping motor phase gate and fault latch
package stepper_pkg;

  // gray order along reset -> run -> fault
  typedef enum logic [1:0] {
    ST_RESET = 2'h0,
    ST_RUN   = 2'h1,
    ST_FAULT = 2'h3
  } drive_state_t;

endpackage : stepper_pkg
